//--- verilog/bertis_pkg.sv
// Constants, register map and carrier types of the test interval sequencer.
package bertis_pkg;

	// Register byte offsets on the AHB-Lite slave.
	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_CMD    = 8'h04;
	localparam logic [7:0] OFF_LEN    = 8'h08;
	localparam logic [7:0] OFF_THRES  = 8'h0C;
	localparam logic [7:0] OFF_STATUS = 8'h10;
	localparam logic [7:0] OFF_SECS   = 8'h14;
	localparam logic [7:0] OFF_TES    = 8'h18;
	localparam logic [7:0] OFF_ERRS   = 8'h1C;

	// Command register bit positions; each bit is a one-shot request.
	localparam int CMD_RUN     = 0;
	localparam int CMD_STOP    = 1;
	localparam int CMD_DISCARD = 2;
	localparam int CMD_PRINT   = 3;

	// Length register field positions (hh:mm:ss).
	localparam int LEN_SS_LSB = 0;
	localparam int LEN_MM_LSB = 8;
	localparam int LEN_HH_LSB = 16;

	// Threshold exponent limits and reset value.
	localparam logic [4:0] THRES_MIN   = 5'h02;
	localparam logic [4:0] THRES_MAX   = 5'h10;
	localparam logic [4:0] THRES_RESET = 5'h06;

	// Squelch run lengths in seconds.
	localparam logic [3:0] SQ_ON_SECS  = 4'hA;
	localparam logic [3:0] SQ_OFF_SECS = 4'h5;

	// Seconds per minute and per hour.
	localparam logic [31:0] SECS_MIN  = 32'h0000003C;
	localparam logic [31:0] SECS_HOUR = 32'h00000E10;

	// One-second tick derived from the 100 MHz clock.
	localparam longint TICK_NS     = 1000000000;
	localparam longint CLK_NS      = 10;
	localparam int     TICK_CYCLES = int'(TICK_NS / CLK_NS);

	// Timing modes; code 2'b11 is never stored.
	typedef enum logic [1:0] {
		BERTIS_UNTIMED = 2'b00,
		BERTIS_TIMED   = 2'b01,
		BERTIS_REPEAT  = 2'b10
	} bertis_mode_t;

	// Report selection.
	typedef enum logic [1:0] {
		BERTIS_REP_EOT  = 2'b00,
		BERTIS_REP_ONER = 2'b01,
		BERTIS_REP_BOTH = 2'b10,
		BERTIS_REP_NONE = 2'b11
	} bertis_report_t;

	// Test process state.
	typedef enum logic {
		BERTIS_STOPPED = 1'b0,
		BERTIS_RUNNING = 1'b1
	} bertis_state_t;

	// Control register layout, bit 5 downward.
	typedef struct packed {
		logic           squelch_en;
		bertis_report_t report;
		logic           prev_sel;
		bertis_mode_t   mode;
	} bertis_ctrl_t;

	// Interval results.
	typedef struct packed {
		logic [31:0] secs;
		logic [31:0] tes;
		logic [31:0] errs;
	} bertis_res_t;

	localparam bertis_ctrl_t CTRL_RESET = '{
		squelch_en: 1'b0,
		report:     BERTIS_REP_NONE,
		prev_sel:   1'b0,
		mode:       BERTIS_UNTIMED
	};

endpackage : bertis_pkg

//--- verilog/bertis_top.sv
// Test interval sequencer with report gating behind an AHB-Lite slave.
//
// Functional notes
// - Untimed test runs until a stop request.
// - Timed test ends itself when test length elapses.
// - Repeat test ends and restarts each length until stopped.
// - Run request starts a test of the selected timing mode.
// - Stop ends untimed and repeat tests, and timed tests early.
// - Status shows run while testing and stop otherwise.
// - Result reads follow current or previous interval selection.
// - Print uses current results when running, previous otherwise.
// - Report selection: end-of-test, on-error, both or neither.
// - With squelch on, on-error reports stop after ten bad seconds.
// - Squelched reports resume after five good seconds in a row.
// - With squelch off, on-error reports are never suppressed.
// - Threshold is ten to minus v, v from 2 to 16.
// - Each second above threshold counts as threshold errored second.
// - On-error reports come from comparing each second to threshold.
// - Timing mode holds exactly three values and reads back.
// - Test length matters only in timed or repeat mode.
// - Run to stop saves results; discard hides them until next.
//
// Local design decisions: the AHB-Lite interface to the registers and the register addresses.
module bertis_top
	import bertis_pkg::*;
#(
	parameter int TICK_LEN = bertis_pkg::TICK_CYCLES
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic [7:0]  err_inc,
	input  wire logic [7:0]  bit_inc,
	output logic             test_running,
	output logic             squelched,
	output logic             eot_evt,
	output logic             onerr_evt,
	output logic             print_evt,
	output logic             print_prev
);
	import bertis_pkg::*;

	// Ten to the power v, wide enough for v up to 16.
	function automatic logic [53:0] pow10(input logic [4:0] v);
		logic [53:0] r;
		r = 54'h1;
		for (int i = 0; i < 16; i++) begin
			if (5'(i) < v) begin
				r = 54'(r * 54'hA);
			end
		end
		return r;
	endfunction : pow10

	// Test length in seconds from the hh:mm:ss fields.
	function automatic logic [31:0] len_secs(input logic [31:0] l);
		logic [31:0] hh;
		logic [31:0] mm;
		hh = {27'h0, l[LEN_HH_LSB +: 5]};
		mm = {26'h0, l[LEN_MM_LSB +: 6]};
		return 32'(hh * SECS_HOUR) + 32'(mm * SECS_MIN)
			+ {26'h0, l[LEN_SS_LSB +: 6]};
	endfunction : len_secs

	////////////////////////////////////////////////////////////////////////
	// Bus state.
	logic        pend_q, pend_d;
	logic        wr_q, wr_d;
	logic [7:0]  addr_q, addr_d;
	logic [31:0] rdata_q, rdata_d;
	logic        rdy_q, rdy_d;

	// Configuration and sequencer state.
	bertis_ctrl_t  ctrl_q, ctrl_d;
	logic [31:0]   len_q, len_d;
	logic [4:0]    thres_q, thres_d;
	bertis_state_t st_q, st_d;
	bertis_res_t   cur_q, cur_d;
	bertis_res_t   prev_q, prev_d;
	logic          pvalid_q, pvalid_d;
	logic [31:0]   tick_q, tick_d;
	logic [63:0]   sbits_q, sbits_d;
	logic [31:0]   serrs_q, serrs_d;
	logic [3:0]    over_q, over_d;
	logic [3:0]    under_q, under_d;
	logic          sq_q, sq_d;
	logic          eot_q, eot_d;
	logic          oner_q, oner_d;
	logic          prt_q, prt_d;
	logic          pprev_q, pprev_d;

	// Decoded write strobes, per-second terms and result selection.
	logic        wdo;
	logic [31:0] cmd;
	logic        tick;
	logic        above;
	logic [85:0] prod;
	logic        done;
	logic        ended;
	bertis_res_t sel;

	////////////////////////////////////////////////////////////////////////
	// AHB-Lite slave: one wait state so read data leaves a flip-flop.
	always_comb begin
		pend_d  = 1'b0;
		wr_d    = wr_q;
		addr_d  = addr_q;
		rdata_d = rdata_q;
		rdy_d   = 1'b1;
		if (pend_q) begin
			rdata_d = 32'h0;
			if (!wr_q) begin
				case (addr_q)
				OFF_CTRL:   rdata_d = {26'h0, ctrl_q};
				OFF_LEN:    rdata_d = len_q;
				OFF_THRES:  rdata_d = {27'h0, thres_q};
				OFF_STATUS: rdata_d = {28'h0, pvalid_q, sq_q,
					1'b0, st_q};
				OFF_SECS:   rdata_d = sel.secs;
				OFF_TES:    rdata_d = sel.tes;
				OFF_ERRS:   rdata_d = sel.errs;
				default:    rdata_d = 32'h0;
				endcase
			end
		end else if (hsel && hready && htrans[1]) begin
			pend_d = 1'b1;
			wr_d   = hwrite;
			addr_d = {haddr[7:2], 2'b00};
			rdy_d  = 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pend_q  <= 1'b0;
			wr_q    <= 1'b0;
			addr_q  <= 8'h00;
			rdata_q <= 32'h0;
			rdy_q   <= 1'b1;
		end else begin
			pend_q  <= pend_d;
			wr_q    <= wr_d;
			addr_q  <= addr_d;
			rdata_q <= rdata_d;
			rdy_q   <= rdy_d;
		end
	end

	// Write strobes and result selection; no previous results read zero.
	assign wdo  = pend_q && wr_q;
	assign cmd  = (wdo && addr_q == OFF_CMD) ? hwdata : 32'h0;
	assign sel  = ctrl_q.prev_sel ? (pvalid_q ? prev_q : '0)
		: cur_q;
	assign tick = (tick_q == 32'(TICK_LEN - 1));
	assign prod = 86'(serrs_q * pow10(thres_q));
	assign above = prod > {22'h0, sbits_q};
	assign done = (ctrl_q.mode != BERTIS_UNTIMED)
		&& (cur_q.secs + 32'h1 >= len_secs(len_q));

	////////////////////////////////////////////////////////////////////////
	// Sequencer, per-second evaluation and report gating.
	always_comb begin
		ctrl_d   = ctrl_q;
		len_d    = len_q;
		thres_d  = thres_q;
		st_d     = st_q;
		cur_d    = cur_q;
		prev_d   = prev_q;
		pvalid_d = pvalid_q;
		tick_d   = tick ? 32'h0 : tick_q + 32'h1;
		sbits_d  = sbits_q + {56'h0, bit_inc};
		serrs_d  = serrs_q + {24'h0, err_inc};
		over_d   = over_q;
		under_d  = under_q;
		sq_d     = sq_q;
		eot_d    = 1'b0;
		oner_d   = 1'b0;
		prt_d    = 1'b0;
		pprev_d  = pprev_q;
		ended    = 1'b0;
		// Settings; the unused mode code is refused so the mode stays legal.
		if (wdo && addr_q == OFF_CTRL
			&& hwdata[1:0] != 2'b11) begin
			ctrl_d = bertis_ctrl_t'(hwdata[5:0]);
		end
		if (wdo && addr_q == OFF_LEN) begin
			len_d = hwdata & 32'h001F3F3F;
		end
		if (wdo && addr_q == OFF_THRES && hwdata[4:0] >= THRES_MIN
			&& hwdata[4:0] <= THRES_MAX
			&& hwdata[31:5] == 27'h0) begin
			thres_d = hwdata[4:0];
		end
		// Error rate accumulators restart every second.
		if (tick) begin
			sbits_d = {56'h0, bit_inc};
			serrs_d = {24'h0, err_inc};
		end
		case (st_q)
		BERTIS_STOPPED: begin
			if (cmd[CMD_RUN]) begin
				st_d   = BERTIS_RUNNING;
				cur_d  = '0;
				tick_d = 32'h0;
				over_d = 4'h0;
				under_d = 4'h0;
				sq_d   = 1'b0;
				sbits_d = {56'h0, bit_inc};
				serrs_d = {24'h0, err_inc};
			end
		end
		BERTIS_RUNNING: begin
			if (tick) begin
				cur_d.secs = cur_q.secs + 32'h1;
				cur_d.errs = cur_q.errs + serrs_q;
				if (above) begin
					cur_d.tes = cur_q.tes + 32'h1;
					under_d   = 4'h0;
					if (!sq_q && ctrl_q.report
						inside {BERTIS_REP_ONER,
						BERTIS_REP_BOTH}) begin
						oner_d = 1'b1;
					end
					if (over_q != SQ_ON_SECS) begin
						over_d = over_q + 4'h1;
					end
					if (ctrl_q.squelch_en
						&& over_q + 4'h1 >= SQ_ON_SECS) begin
						sq_d = 1'b1;
					end
				end else begin
					over_d = 4'h0;
					if (under_q != SQ_OFF_SECS) begin
						under_d = under_q + 4'h1;
					end
					if (under_q + 4'h1 >= SQ_OFF_SECS) begin
						sq_d = 1'b0;
					end
				end
				if (done) begin
					ended = 1'b1;
				end
			end
			if (cmd[CMD_STOP]) begin
				ended = 1'b1;
			end
			if (ended) begin
				prev_d = cur_d;
				pvalid_d = 1'b1;
				eot_d = ctrl_q.report inside
					{BERTIS_REP_EOT, BERTIS_REP_BOTH};
				if (ctrl_q.mode == BERTIS_REPEAT
					&& !cmd[CMD_STOP]) begin
					cur_d = '0;
				end else begin
					st_d = BERTIS_STOPPED;
				end
			end
		end
		default: st_d = BERTIS_STOPPED;
		endcase
		// Squelch off means no suppression at all.
		if (!ctrl_q.squelch_en) begin
			sq_d = 1'b0;
		end
		// A discard loses to a test end in the same cycle.
		if (cmd[CMD_DISCARD] && !ended) begin
			pvalid_d = 1'b0;
		end
		if (cmd[CMD_PRINT]) begin
			prt_d   = 1'b1;
			pprev_d = (st_q == BERTIS_STOPPED);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q   <= CTRL_RESET;
			len_q    <= 32'h0;
			thres_q  <= THRES_RESET;
			st_q     <= BERTIS_STOPPED;
			cur_q    <= '0;
			prev_q   <= '0;
			pvalid_q <= 1'b0;
			tick_q   <= 32'h0;
			sbits_q  <= 64'h0;
			serrs_q  <= 32'h0;
			over_q   <= 4'h0;
			under_q  <= 4'h0;
			sq_q     <= 1'b0;
			eot_q    <= 1'b0;
			oner_q   <= 1'b0;
			prt_q    <= 1'b0;
			pprev_q  <= 1'b0;
		end else begin
			ctrl_q   <= ctrl_d;
			len_q    <= len_d;
			thres_q  <= thres_d;
			st_q     <= st_d;
			cur_q    <= cur_d;
			prev_q   <= prev_d;
			pvalid_q <= pvalid_d;
			tick_q   <= tick_d;
			sbits_q  <= sbits_d;
			serrs_q  <= serrs_d;
			over_q   <= over_d;
			under_q  <= under_d;
			sq_q     <= sq_d;
			eot_q    <= eot_d;
			oner_q   <= oner_d;
			prt_q    <= prt_d;
			pprev_q  <= pprev_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs straight from flip-flops; the response is always OKAY.
	assign hrdata       = rdata_q;
	assign hreadyout    = rdy_q;
	assign hresp        = 1'b0;
	assign test_running = (st_q == BERTIS_RUNNING);
	assign squelched    = sq_q;
	assign eot_evt      = eot_q;
	assign onerr_evt    = oner_q;
	assign print_evt    = prt_q;
	assign print_prev   = pprev_q;

endmodule : bertis_top

//--- verif/bertis_ctl.sv
// Controller model that issues register accesses as an AHB-Lite master.
module bertis_ctl (
	input  wire logic        hclk,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	output logic             hsel,
	output logic [31:0]      haddr,
	output logic [1:0]       htrans,
	output logic             hwrite,
	output logic [2:0]       hsize,
	output logic [31:0]      hwdata
);
	timeunit 1ns;
	timeprecision 1ns;

	// Idle bus at time zero; only whole words are ever sent.
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end

	// One single transfer; the address phase is held until hready is seen.
	task automatic xfer(input logic w, input logic [7:0] a,
			input logic [31:0] d, output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		haddr <= ~haddr;
		// A read leaves stale write data changing so nothing relies on it.
		hwdata <= w ? d : ~hwdata;
		do @(posedge hclk); while (hready !== 1'b1);
		q = hrdata;
	endtask : xfer
endmodule : bertis_ctl

//--- verif/bertis_top_sva.sv
// Checker of event and status relations at the sequencer ports.
module bertis_chk #(
	parameter int TICK_LEN = 20
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hreadyout,
	input wire logic test_running,
	input wire logic squelched,
	input wire logic eot_evt,
	input wire logic onerr_evt,
	input wire logic print_evt,
	input wire logic print_prev
);
	timeunit 1ns;
	timeprecision 1ns;
	int gap_q;
	int gap_d;

	// Cycles since the last on-error event, saturating at one tick.
	always_comb begin
		gap_d = gap_q;
		if (onerr_evt)
			gap_d = 0;
		else if (gap_q < TICK_LEN)
			gap_d = gap_q + 1;
	end

	// Starts saturated so the first report after reset is legal.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			gap_q <= TICK_LEN;
		else
			gap_q <= gap_d;
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	////////////////////////////////////////////////////////////////////////
	property p_on_gap;
		onerr_evt |-> gap_q >= TICK_LEN - 1;
	endproperty
	a_on_gap: assert property (p_on_gap) else $error("on-error too soon");
	property p_on_run;
		onerr_evt |-> $past(test_running);
	endproperty
	a_on_run: assert property (p_on_run) else $error("on-error idle");
	property p_on_sq;
		onerr_evt |-> !$past(squelched);
	endproperty
	a_on_sq: assert property (p_on_sq) else $error("on-error squelched");
	property p_eot_one;
		eot_evt |=> !eot_evt;
	endproperty
	a_eot_one: assert property (p_eot_one) else $error("end event long");
	property p_eot_run;
		eot_evt |-> $past(test_running);
	endproperty
	a_eot_run: assert property (p_eot_run) else $error("end event idle");
	property p_prt_prev;
		print_evt |-> print_prev == !$past(test_running);
	endproperty
	a_prt_prev: assert property (p_prt_prev) else $error("print source");
	property p_run_cmd;
		$rose(test_running) |-> $past(!hreadyout) || $past(!hreadyout, 2)
			|| $past(!hreadyout, 3);
	endproperty
	a_run_cmd: assert property (p_run_cmd) else $error("start no access");
	property p_sq_run;
		$rose(squelched) |-> $past(test_running);
	endproperty
	a_sq_run: assert property (p_sq_run) else $error("squelch idle");
endmodule : bertis_chk

bind bertis_top bertis_chk #(.TICK_LEN(TICK_LEN)) u_chk (
	.hclk(hclk),
	.hresetn(hresetn),
	.hreadyout(hreadyout),
	.test_running(test_running),
	.squelched(squelched),
	.eot_evt(eot_evt),
	.onerr_evt(onerr_evt),
	.print_evt(print_evt),
	.print_prev(print_prev)
);

//--- verif/bertis_top_tb.sv
// Self-checking bench of the test interval sequencer.
module bertis_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import bertis_pkg::*;
	typedef struct packed {
		logic        w;
		logic [7:0]  a;
		logic [31:0] d;
		logic [31:0] e;
	} bertis_row_t;
	localparam int TL = 20;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic [7:0]  err_inc = 8'h0;
	logic [7:0]  bit_inc = 8'h0;
	logic        test_running;
	logic        squelched;
	logic        eot_evt;
	logic        onerr_evt;
	logic        print_evt;
	logic        print_prev;
	logic        pp = 1'bx;
	int          n_errors = 0;
	int          checks = 0;
	int          n_on = 0;
	int          n_eot = 0;
	int          cyc = 0;
	// Reset values first, then write and read back, refusals included.
	bertis_row_t rows [15] = '{
		'{1'b0, OFF_CTRL, 32'h0, 32'h18},
		'{1'b0, OFF_THRES, 32'h0, 32'h6},
		'{1'b0, OFF_LEN, 32'h0, 32'h0},
		'{1'b1, OFF_CTRL, 32'h22, 32'h22},
		'{1'b1, OFF_CTRL, 32'h3, 32'h22},
		'{1'b1, OFF_CTRL, 32'h9, 32'h9},
		'{1'b1, OFF_CTRL, 32'h11, 32'h11},
		'{1'b1, OFF_CTRL, 32'h0, 32'h0},
		'{1'b1, OFF_THRES, 32'h10, 32'h10},
		'{1'b1, OFF_THRES, 32'h11, 32'h10},
		'{1'b1, OFF_THRES, 32'h1, 32'h10},
		'{1'b1, OFF_THRES, 32'h2, 32'h2},
		'{1'b1, OFF_LEN, 32'hFFFFFFFF, 32'h001F3F3F},
		'{1'b1, OFF_STATUS, 32'hF, 32'h0},
		'{1'b1, 8'h20, 32'h5, 32'h0}
	};

	bertis_top #(.TICK_LEN(TL)) uut (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.err_inc(err_inc), .bit_inc(bit_inc), .test_running(test_running),
		.squelched(squelched), .eot_evt(eot_evt), .onerr_evt(onerr_evt),
		.print_evt(print_evt), .print_prev(print_prev));
	bertis_ctl u_ctl (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata));

	////////////////////////////////////////////////////////////////////////
	always #5 hclk = ~hclk;

	// Event counts, print source capture and the hang limit.
	always @(posedge hclk) begin
		cyc++;
		if (onerr_evt === 1'b1) n_on++;
		if (eot_evt === 1'b1) n_eot++;
		if (print_evt === 1'b1) pp <= print_prev;
		if (cyc == 4000) begin
			n_errors++;
			conclude();
		end
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		u_ctl.xfer(1'b0, a, 32'h0, q);
		chk(q, e);
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		u_ctl.xfer(1'b1, a, d, q);
	endtask : wr
	// Waits whole seconds plus a little slack for the event latency.
	task automatic secs(input int n);
		repeat (n * TL + 3) @(posedge hclk);
	endtask : secs
	task automatic wait_stop(input int n);
		for (int k = 0; k < n && test_running !== 1'b0; k++) @(posedge hclk);
		// One more edge so the event counters have seen the last pulse.
		@(posedge hclk);
	endtask : wait_stop
	task automatic conclude;
		$display("checks %0d, mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : conclude

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		foreach (rows[i]) begin
			if (rows[i].w) wr(rows[i].a, rows[i].d);
			rd(rows[i].a, rows[i].e);
			chk(32'(hresp), 32'h0);
		end
		$display("test registers done");
		// Timed three seconds, every second far above the threshold.
		wr(OFF_LEN, 32'h3);
		wr(OFF_CTRL, 32'h11);
		err_inc <= 8'h01;
		bit_inc <= 8'h08;
		n_on = 0;
		n_eot = 0;
		wr(OFF_CMD, 32'h1);
		wait_stop(5 * TL);
		chk(n_on, 3);
		chk(n_eot, 1);
		wr(OFF_CTRL, 32'h15);
		rd(OFF_SECS, 32'h3);
		rd(OFF_TES, 32'h3);
		rd(OFF_STATUS, 32'h8);
		wr(OFF_CMD, 32'h4);
		rd(OFF_STATUS, 32'h0);
		rd(OFF_SECS, 32'h0);
		$display("test timed done");
		// Untimed keeps going; print follows the run state.
		wr(OFF_CMD, 32'h8);
		repeat (3) @(posedge hclk);
		chk(32'(pp), 32'h1);
		wr(OFF_CTRL, 32'h18);
		wr(OFF_CMD, 32'h1);
		secs(4);
		rd(OFF_STATUS, 32'h1);
		wr(OFF_CMD, 32'h8);
		repeat (3) @(posedge hclk);
		chk(32'(pp), 32'h0);
		wr(OFF_CMD, 32'h2);
		wait_stop(5);
		chk(32'(test_running), 32'h0);
		$display("test untimed done");
		// Repeat with one-second length restarts without dropping run.
		wr(OFF_LEN, 32'h1);
		wr(OFF_CTRL, 32'h2);
		n_eot = 0;
		wr(OFF_CMD, 32'h1);
		secs(3);
		chk(n_eot, 3);
		chk(32'(test_running), 32'h1);
		wr(OFF_CMD, 32'h2);
		$display("test repeat done");
		// Squelch after ten bad seconds, release after five good ones.
		wr(OFF_CTRL, 32'h28);
		n_on = 0;
		wr(OFF_CMD, 32'h1);
		secs(12);
		chk(n_on, 10);
		chk(32'(squelched), 32'h1);
		err_inc <= 8'h00;
		secs(7);
		chk(32'(squelched), 32'h0);
		wr(OFF_CMD, 32'h2);
		wr(OFF_CTRL, 32'h08);
		err_inc <= 8'h01;
		n_on = 0;
		wr(OFF_CMD, 32'h1);
		secs(12);
		chk(n_on, 12);
		chk(32'(squelched), 32'h0);
		$display("test squelch done");
		// Reset in mid-run drops the test and restores the settings.
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		chk(32'(test_running), 32'h0);
		chk(32'(squelched), 32'h0);
		hresetn <= 1'b1;
		rd(OFF_CTRL, 32'h18);
		rd(OFF_STATUS, 32'h0);
		$display("test reset done");
		conclude();
	end
endmodule : bertis_top_tb
